// *** inc/audio_front_regs.vh ***
// Constants of the audio input clock and reset front end
`ifndef AUDIO_FRONT_REGS_VH
`define AUDIO_FRONT_REGS_VH
// ----------------------------------------
// Initialization and detection counts
// ----------------------------------------
`define AF_INIT_CYCLES 11'h400
`define AF_SILENCE_PERIODS 11'h400
`define AF_DRIFT_BCK 11'h006
`define AF_RATIO_TOL 11'h002
`define AF_PERIOD_MAX 11'h7ff
// ----------------------------------------
// Clock ratios in system clocks per frame, and their ratio codes
// ----------------------------------------
`define AF_R128 11'h080
`define AF_R192 11'h0c0
`define AF_R256 11'h100
`define AF_R384 11'h180
`define AF_R512 11'h200
`define AF_R768 11'h300
`define AF_RC_128 3'h0
`define AF_RC_192 3'h1
`define AF_RC_256 3'h2
`define AF_RC_384 3'h3
`define AF_RC_512 3'h4
`define AF_RC_768 3'h5
`define AF_RC_NONE 3'h7
// ----------------------------------------
// Serial word layout and formats
// ----------------------------------------
`define AF_WORD_LAST 6'h17
`define AF_FMT_RJ 2'h0
`define AF_FMT_I2S 2'h1
`define AF_FMT_LJ 2'h2
`define AF_BPZ 24'h000000
`endif

// *** rtl/silence_detect.v ***
// Per-channel run length detector of all-low words
`include "audio_front_regs.vh"
module silence_detect (
  input wire clk,
  input wire rst,
  input wire clear,
  input wire bitStrobe,
  input wire dataBit,
  input wire periodEnd,
  output reg flag
);
  reg sawOne;
  reg [10:0] runCount;
  wire oneNow;
  assign oneNow = bitStrobe & dataBit;
  // ----------------------------------------
  // Count whole periods of low data
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sawOne <= 1'b0;
      runCount <= 11'h000;
      flag <= 1'b0;
    end else if (clear) begin
      sawOne <= 1'b0;
      runCount <= 11'h000;
      flag <= 1'b0;
    end else if (periodEnd) begin
      sawOne <= oneNow;
      if (sawOne | oneNow) begin
        runCount <= 11'h000;
        flag <= 1'b0;
      end else if (runCount != `AF_SILENCE_PERIODS) begin
        runCount <= runCount + 11'h001;
        flag <= (runCount == `AF_SILENCE_PERIODS - 11'h001); // R14
      end
    end else if (oneNow) begin
      sawOne <= 1'b1;
    end
  end
endmodule

// *** rtl/audio_input_clock_reset_front.v ***
// Clock ratio detection, reset sequencing and serial audio input
// Contract
// R1 - Ratio detected automatically, no setting
// R2 - Source avoids 512/768 ratios at 192 kHz
// R3 - 128x modulator needs clock above 256x
// R4 - Power-up: 1024 cycles then default state
// R5 - Reset pin held low at least 20 ns
// R6 - Reset pin release: 1024 cycles initialization
// R7 - Data sampled on bit clock rising edge
// R8 - Word select frames left and right words
// R9 - Word select frequency-locked to system clock
// R10 - Drift over 6 bit clocks: reinit, mute
// R11 - Readback open-drain in I2C, else push-pull
// R12 - Host avoids unsupported fast-mode clock ratios
// R13 - Select low means SPI, high I2C
// R14 - Silence flag after 1024 low periods
// R15 - Sender sends two's-complement, MSB first
// R16 - Ratio found by counting clocks per frame
`include "audio_front_regs.vh"
module audio_input_clock_reset_front (
  input wire ref_clk,
  input wire sys_rst,
  input wire resetPinN,
  input wire serialBitClock,
  input wire wordSelectClock,
  input wire serialData,
  input wire controlPortSelect,
  input wire [1:0] formatSelect,
  input wire readbackBit,
  output reg controlReadbackOut,
  output reg controlReadbackOe,
  output reg i2cMode,
  output reg initDone,
  output reg [2:0] ratioCode,
  output reg ratioLocked,
  output reg muteOut,
  output reg [23:0] leftSample,
  output reg [23:0] rightSample,
  output reg sampleValid,
  output wire leftSilenceFlag,
  output wire rightSilenceFlag
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function near;
    input [10:0] p;
    input [10:0] r;
    begin
      near = (p + `AF_RATIO_TOL >= r) && (p <= r + `AF_RATIO_TOL);
    end
  endfunction

  function [2:0] matchRatio;
    input [10:0] p;
    begin
      matchRatio = `AF_RC_NONE;
      if (near(p, `AF_R128)) matchRatio = `AF_RC_128;
      if (near(p, `AF_R192)) matchRatio = `AF_RC_192;
      if (near(p, `AF_R256)) matchRatio = `AF_RC_256;
      if (near(p, `AF_R384)) matchRatio = `AF_RC_384;
      if (near(p, `AF_R512)) matchRatio = `AF_RC_512;
      if (near(p, `AF_R768)) matchRatio = `AF_RC_768;
    end
  endfunction

  function [10:0] ratioCount;
    input [2:0] c;
    begin
      case (c)
        `AF_RC_128: ratioCount = `AF_R128;
        `AF_RC_192: ratioCount = `AF_R192;
        `AF_RC_256: ratioCount = `AF_R256;
        `AF_RC_384: ratioCount = `AF_R384;
        `AF_RC_512: ratioCount = `AF_R512;
        default: ratioCount = `AF_R768;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [4:0] pinIn;
  reg [4:0] syncA;
  reg [4:0] syncB;
  reg [4:0] syncC;
  reg [4:0] level;
  reg [4:0] levelQ;
  assign pinIn = {controlPortSelect, resetPinN, serialData, wordSelectClock, serialBitClock};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : pinSync
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
          syncC[g] <= 1'b0;
          level[g] <= 1'b0;
          levelQ[g] <= 1'b0;
        end else begin
          syncA[g] <= pinIn[g];
          syncB[g] <= syncA[g];
          syncC[g] <= syncB[g];
          if (syncB[g] == syncC[g]) begin
            level[g] <= syncC[g];
          end
          levelQ[g] <= level[g];
        end
      end
    end
  endgenerate
  wire bckRise;
  wire wsLevel;
  wire wsEdge;
  wire wsRise;
  wire dataLevel;
  wire rstPinHigh;
  assign bckRise = level[0] & ~levelQ[0]; // R7
  assign wsLevel = level[1];
  assign wsEdge = level[1] ^ levelQ[1]; // R8
  assign wsRise = level[1] & ~levelQ[1];
  assign dataLevel = level[2];
  assign rstPinHigh = level[3];

  // ----------------------------------------
  // Initialization sequence
  // ----------------------------------------
  reg [10:0] initCount;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      initCount <= 11'h000;
      initDone <= 1'b0;
    end else if (!rstPinHigh) begin
      initCount <= 11'h000; // R6
      initDone <= 1'b0;
    end else if (initCount != `AF_INIT_CYCLES) begin
      initCount <= initCount + 11'h001; // R4
      initDone <= (initCount == `AF_INIT_CYCLES - 11'h001); // R6
    end
  end

  // ----------------------------------------
  // Control port select and readback pin
  // ----------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      i2cMode <= 1'b0;
      controlReadbackOut <= 1'b0;
      controlReadbackOe <= 1'b0;
    end else begin
      i2cMode <= level[4]; // R13
      controlReadbackOut <= level[4] ? 1'b0 : readbackBit; // R11
      controlReadbackOe <= level[4] ? ~readbackBit : 1'b1; // R11
    end
  end

  // ----------------------------------------
  // Ratio detection and lock supervision
  // ----------------------------------------
  reg [10:0] sysCount;
  reg [10:0] phaseCount;
  reg [7:0] bckCount;
  reg [7:0] bckPeriod;
  reg [2:0] prevCode;
  wire [10:0] periodNow;
  wire [2:0] curCode;
  wire [10:0] nominal;
  wire [10:0] phaseDev;
  wire [10:0] driftLimit;
  wire driftLost;
  wire timeoutLost;
  assign periodNow = sysCount + 11'h001;
  assign curCode = matchRatio(periodNow); // R16
  assign nominal = ratioCount(ratioCode);
  assign phaseDev = (phaseCount < {1'b0, nominal[10:1]}) ? phaseCount : nominal - phaseCount;
  assign driftLimit = {3'h0, bckPeriod} * `AF_DRIFT_BCK;
  assign driftLost = ratioLocked && wsRise && (phaseDev > driftLimit); // R10
  assign timeoutLost = ratioLocked && (sysCount > nominal + driftLimit); // R10

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysCount <= 11'h000;
      phaseCount <= 11'h000;
      bckCount <= 8'h00;
      bckPeriod <= 8'h00;
      prevCode <= `AF_RC_NONE;
      ratioCode <= `AF_RC_NONE;
      ratioLocked <= 1'b0;
      muteOut <= 1'b1;
    end else if (!initDone) begin
      sysCount <= 11'h000;
      phaseCount <= 11'h000;
      bckCount <= 8'h00;
      bckPeriod <= 8'h00;
      prevCode <= `AF_RC_NONE;
      ratioCode <= `AF_RC_NONE;
      ratioLocked <= 1'b0;
      muteOut <= 1'b1;
    end else begin
      if (bckRise) begin
        bckCount <= 8'h01;
        bckPeriod <= bckCount;
      end else if (bckCount != 8'hff) begin
        bckCount <= bckCount + 8'h01;
      end
      if (wsRise) begin
        sysCount <= 11'h000;
      end else if (sysCount != `AF_PERIOD_MAX) begin
        sysCount <= periodNow;
      end
      if (phaseCount == nominal - 11'h001) begin
        phaseCount <= 11'h000;
      end else begin
        phaseCount <= phaseCount + 11'h001;
      end
      if (driftLost || timeoutLost) begin
        ratioLocked <= 1'b0; // R10
        prevCode <= `AF_RC_NONE;
        muteOut <= 1'b1; // R10
      end else if (wsRise && !ratioLocked) begin
        prevCode <= curCode;
        if (curCode != `AF_RC_NONE && curCode == prevCode) begin
          ratioLocked <= 1'b1; // R1
          ratioCode <= curCode; // R16
          phaseCount <= 11'h001;
          muteOut <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Serial word capture
  // ----------------------------------------
  reg [23:0] shiftReg;
  reg [5:0] bitCount;
  wire [5:0] curIdx;
  wire [5:0] lastIdx;
  wire leftLevel;
  wire [23:0] fullWord;
  wire rjDone;
  wire alignedDone;
  wire wordDone;
  wire wordIsLeft;
  wire [23:0] doneWord;
  assign curIdx = wsEdge ? 6'h00 : bitCount;
  assign lastIdx = (formatSelect == `AF_FMT_I2S) ? `AF_WORD_LAST + 6'h01 : `AF_WORD_LAST;
  assign leftLevel = (formatSelect != `AF_FMT_I2S);
  assign fullWord = {shiftReg[22:0], dataLevel};
  assign rjDone = (formatSelect == `AF_FMT_RJ) && wsEdge;
  assign alignedDone = (formatSelect != `AF_FMT_RJ) && bckRise && (curIdx == lastIdx);
  assign wordDone = rjDone | alignedDone;
  assign wordIsLeft = rjDone ? (levelQ[1] == leftLevel) : (wsLevel == leftLevel); // R8
  assign doneWord = rjDone ? shiftReg : fullWord;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shiftReg <= 24'h000000;
      bitCount <= 6'h00;
      leftSample <= `AF_BPZ;
      rightSample <= `AF_BPZ;
      sampleValid <= 1'b0;
    end else if (!initDone || muteOut) begin
      shiftReg <= 24'h000000;
      bitCount <= 6'h00;
      leftSample <= `AF_BPZ; // R10
      rightSample <= `AF_BPZ; // R10
      sampleValid <= 1'b0;
    end else begin
      if (bckRise) begin
        shiftReg <= fullWord; // R7
      end
      if (wsEdge) begin
        bitCount <= bckRise ? 6'h01 : 6'h00;
      end else if (bckRise && bitCount != 6'h3f) begin
        bitCount <= bitCount + 6'h01;
      end
      sampleValid <= wordDone && !wordIsLeft;
      if (wordDone && wordIsLeft) begin
        leftSample <= doneWord;
      end
      if (wordDone && !wordIsLeft) begin
        rightSample <= doneWord;
      end
    end
  end

  // ----------------------------------------
  // Silence flags
  // ----------------------------------------
  wire [1:0] silence;
  wire chanClear;
  assign chanClear = !initDone;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chanSilence
      silence_detect u_silence (
        .clk(ref_clk),
        .rst(sys_rst),
        .clear(chanClear),
        .bitStrobe(bckRise && ((wsLevel == leftLevel) ^ (g == 1))),
        .dataBit(dataLevel),
        .periodEnd(wsRise),
        .flag(silence[g])
      );
    end
  endgenerate
  assign leftSilenceFlag = silence[0]; // R14
  assign rightSilenceFlag = silence[1]; // R14
endmodule

// *** tb/audio_front_assertions.sv ***
// Port assertions of the audio input clock and reset front end
`include "audio_front_regs.vh"
module audio_front_assertions #(
  parameter int FRAME_LIMIT = 620
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire resetPinN,
  input wire wordSelectClock,
  input wire controlPortSelect,
  input wire readbackBit,
  input wire controlReadbackOut,
  input wire controlReadbackOe,
  input wire i2cMode,
  input wire initDone,
  input wire ratioLocked,
  input wire muteOut,
  input wire [23:0] leftSample,
  input wire [23:0] rightSample,
  input wire sampleValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] hiCnt, wsGap;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hiCnt <= 12'h000;
      wsGap <= 12'h000;
    end else begin
      hiCnt <= resetPinN ? hiCnt + {11'h000, hiCnt != 12'hfff} : 12'h000;
      wsGap <= $rose(wordSelectClock) ? 12'h000 : wsGap + 12'h001;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_init; $rose(initDone) |-> hiCnt >= 12'd1024 && hiCnt <= 12'd1040; endproperty
  a_init: assert property (p_init) else $error("init length");
  property p_pin; $fell(resetPinN) |-> ##[1:8] !initDone; endproperty
  a_pin: assert property (p_pin) else $error("pin reset");
  property p_idle; !initDone && !$past(initDone) |-> muteOut && !ratioLocked && !sampleValid; endproperty
  a_idle: assert property (p_idle) else $error("idle state");
  property p_bpz; muteOut && $past(muteOut) |-> (leftSample | rightSample) == `AF_BPZ; endproperty
  a_bpz: assert property (p_bpz) else $error("mute level");
  property p_gap; ratioLocked |-> wsGap <= FRAME_LIMIT; endproperty
  a_gap: assert property (p_gap) else $error("late unlock");
  property p_i2c; initDone && i2cMode && $past(i2cMode) |->
    !controlReadbackOut && controlReadbackOe == !$past(readbackBit); endproperty
  a_i2c: assert property (p_i2c) else $error("open drain");
  property p_spi; initDone && !i2cMode && !$past(i2cMode) |->
    controlReadbackOe && controlReadbackOut == $past(readbackBit); endproperty
  a_spi: assert property (p_spi) else $error("push pull");
  property p_sel; controlPortSelect [*6] |-> i2cMode; endproperty
  a_sel: assert property (p_sel) else $error("select");
  c_lock: cover property ($rose(ratioLocked));
  c_valid: cover property (sampleValid);
  c_unlock: cover property ($fell(ratioLocked) && initDone);
endmodule
bind audio_input_clock_reset_front audio_front_assertions #(.FRAME_LIMIT(620)) checkU (.*);

// *** tb/pcm_sender.sv ***
// Serial PCM sender model, 2 x half bit clocks a frame, RJ, I2S or LJ
`include "audio_front_regs.vh"
module pcm_sender (
  input wire run,
  input wire [3:0] slip,
  input wire [5:0] half,
  input wire [1:0] fmt,
  input wire [23:0] leftWord,
  input wire [23:0] rightWord,
  output logic bitClk,
  output logic wordSel,
  output logic dataOut
);
  timeunit 1ns;
  timeprecision 1ns;
  int f, h, j;
  initial begin
    bitClk = 1'b0;
    wordSel = 1'b0;
    dataOut = 1'b0;
  end
  always begin
    if (run !== 1'b1) begin
      #100;
      dataOut = ~dataOut;
    end else begin
      f = fmt;
      h = half;
      for (int b = 0; b < 2 * h; b++) begin
        j = b % h - (f == `AF_FMT_RJ ? h - 24 : f == `AF_FMT_I2S ? 1 : 0);
        wordSel = (b < h) ^ (f == `AF_FMT_I2S);
        dataOut = (j < 0 || j > 23) ? 1'b0 : b < h ? leftWord[23 - j] : rightWord[23 - j];
        #400 bitClk = 1'b1;
        #400 bitClk = 1'b0;
      end
      dataOut = ~dataOut;
      #(slip * 800);
    end
  end
endmodule

// *** tb/test_audio_input_clock_reset_front.sv ***
// Self-checking bench of the audio input clock and reset front end
`include "audio_front_regs.vh"
module test_audio_input_clock_reset_front;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, sys_rst = 1'b1, resetPinN = 1'b1, readbackBit = 1'b0, run = 1'b0;
  logic controlPortSelect = 1'b0;
  logic [1:0] formatSelect = `AF_FMT_LJ;
  logic [3:0] slip = 4'h0;
  logic [5:0] half = 6'h20;
  logic [23:0] lw = 24'h000000, rw = 24'h000000;
  wire serialBitClock, wordSelectClock, serialData;
  logic controlReadbackOut, controlReadbackOe, i2cMode, initDone, ratioLocked, muteOut;
  logic [2:0] ratioCode;
  logic [23:0] leftSample, rightSample;
  logic sampleValid, leftSilenceFlag, rightSilenceFlag;
  int n_fail = 0, cmp_count = 0, cycles = 0;
  audio_input_clock_reset_front DUT (.*);
  pcm_sender sender (.run(run), .slip(slip), .half(half), .fmt(formatSelect),
    .leftWord(lw), .rightWord(rw),
    .bitClk(serialBitClock), .wordSel(wordSelectClock), .dataOut(serialData));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (++cycles == 60000) begin
      n_fail++;
      give_verdict();
    end
  task chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task t_init;
    int k;
    for (k = 0; k < 1100 && initDone !== 1'b1; k++)
      @(negedge ref_clk);
    chk(k >= 1024 && k <= 1040, 1);
    chk({muteOut, ratioLocked, sampleValid}, 3'b100);
  endtask
  task t_pin;
    resetPinN = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk(initDone, 0);
    resetPinN = 1'b1;
    t_init();
  endtask
  task waitValid;
    int k;
    @(negedge ref_clk);
    for (k = 0; k < 1600 && sampleValid !== 1'b1; k++)
      @(negedge ref_clk);
    chk(sampleValid, 1);
  endtask
  task t_audio;
    logic [23:0] tbl [4] = '{24'h800001, 24'h7ffffe, 24'h5a5a5a, 24'h0000ff};
    run = 1'b1;
    for (int i = 0; i < 4; i += 2) begin
      lw = tbl[i];
      rw = tbl[i + 1];
      waitValid();
      chk(leftSample, tbl[i]);
      chk(rightSample, tbl[i + 1]);
    end
    chk(ratioCode, `AF_RC_512);
    chk({leftSilenceFlag, rightSilenceFlag}, 2'b00);
  endtask
  task t_drift;
    int k;
    slip = 4'h8;
    for (k = 0; k < 700 && muteOut !== 1'b1; k++)
      @(negedge ref_clk);
    chk(k < 512, 1);
    slip = 4'h0;
    @(negedge ref_clk);
    chk(ratioLocked, 0);
    chk(leftSample | rightSample, `AF_BPZ);
    waitValid();
    chk(leftSample, lw);
  endtask
  task t_readback;
    for (int m = 0; m < 4; m++) begin
      controlPortSelect = m[1];
      readbackBit = m[0];
      repeat (8) @(negedge ref_clk);
      chk(i2cMode, m[1]);
      chk({controlReadbackOe, controlReadbackOut}, m[1] ? {~m[0], 1'b0} : {1'b1, m[0]});
    end
  endtask
  task t_formats;
    for (int f = 0; f < 2; f++) begin
      formatSelect = f ? `AF_FMT_I2S : `AF_FMT_RJ;
      lw = f ? 24'h123456 : 24'hfedcba;
      rw = f ? 24'h00fff0 : 24'h0f0f0f;
      repeat (2600) @(negedge ref_clk);
      waitValid();
      chk(leftSample, lw);
      chk(rightSample, rw);
    end
  endtask
  task t_silence;
    int k;
    formatSelect = `AF_FMT_LJ;
    lw = 24'h000000;
    rw = 24'h000000;
    half = 6'h02;
    for (k = 0; k < 36000 && {leftSilenceFlag, rightSilenceFlag} !== 2'b11; k++)
      @(negedge ref_clk);
    chk(k > 32000, 1);
    chk({leftSilenceFlag, rightSilenceFlag}, 2'b11);
    lw = 24'h400000;
    repeat (100) @(negedge ref_clk);
    chk({leftSilenceFlag, rightSilenceFlag}, 2'b01);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_init();
    t_pin();
    t_readback();
    t_audio();
    t_drift();
    t_formats();
    t_silence();
    give_verdict();
  end
endmodule
